// file: include/ict_params.svh
`ifndef ICT_PARAMS_SVH
`define ICT_PARAMS_SVH
// clock period of core_clk_i in ns
`define ICT_CLK_PERIOD_NS 10
// width of clock-period and bus-cycle counts
`define ICT_CLK_W   8
`define ICT_CYC_W   5
// operand sizes
`define ICT_SZ_BYTE 2'h0
`define ICT_SZ_WORD 2'h1
`define ICT_SZ_LONG 2'h2
// one bus cycle occupies this many processor clock periods
`define ICT_BUS_CLKS 8'h04
`endif

// file: include/ict_pkg.sv
package ict_pkg;
	// instruction classes handled by the timing sequencer
	typedef enum logic [4:0] {
		ICT_ADD_IMMEDIATE,
		ICT_AND_IMMEDIATE,
		ICT_XOR_IMMEDIATE,
		ICT_OR_IMMEDIATE,
		ICT_SUBTRACT_IMMEDIATE,
		ICT_COMPARE_IMMEDIATE,
		ICT_ADD_QUICK,
		ICT_SUBTRACT_QUICK,
		ICT_CLEAR_OPERAND,
		ICT_TWOS_COMPLEMENT_OP,
		ICT_EXTENDED_TWOS_COMPLEMENT_OP,
		ICT_LOGICAL_COMPLEMENT,
		ICT_DECIMAL_NEGATE,
		ICT_SET_ON_CONDITION,
		ICT_TEST_AND_SET,
		ICT_OPERAND_TEST,
		ICT_SHIFT_ROTATE,
		ICT_BIT_TOGGLE,
		ICT_BIT_CLEAR,
		ICT_BIT_SET,
		ICT_BIT_TEST,
		ICT_COND_JUMP,
		ICT_UNCONDITIONAL_RELATIVE_JUMP,
		ICT_RELATIVE_SUBROUTINE_CALL,
		ICT_DECREMENT_AND_LOOP,
		ICT_BOUNDS_CHECK,
		ICT_OVERFLOW_TRAP
	} ict_op_t;

	// destination / operand location
	typedef enum logic [1:0] {
		ICT_DST_DATA,
		ICT_DST_ADDR,
		ICT_DST_MEM
	} ict_dst_t;

	// base timing entry: clocks, reads, writes, plus-mark
	typedef struct packed {
		logic [7:0] clks;
		logic [4:0] rd;
		logic [4:0] wr;
		logic       plus;
	} ict_entry_t;
endpackage

// file: include/ict_bus_if.sv
`timescale 1ns/100ps
`default_nettype none
// bus-cycle request/acknowledge between sequencer and bus cycle engine
interface ict_bus_if;
	logic req;   // start one bus cycle
	logic wr;    // 1 write, 0 read
	logic done;  // cycle completed by memory
	logic busy;  // cycle in progress
	modport seq (output req, output wr, input done, input busy);
	modport eng (input req, input wr, output done, output busy);
endinterface
`default_nettype wire

// file: hw/ict_bus_engine.sv
`timescale 1ns/100ps
`default_nettype none
`include "ict_params.svh"
// runs one external bus cycle per request and waits for memory to finish it
module ict_bus_engine (
	input  wire logic core_clk_i,
	input  wire logic rst_i,
	ict_bus_if.eng    bus,
	output logic      mem_req_o,
	output logic      mem_we_o,
	input  wire logic mem_ack_i
);
	////////////////////////////////////////////////////////////////////////
	// one outstanding cycle at a time; strobe held until acknowledged
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			mem_req_o <= 1'b0;
			mem_we_o  <= 1'b0;
		end else if (mem_req_o && mem_ack_i) begin
			mem_req_o <= 1'b0;
		end else if (!mem_req_o && bus.req) begin
			mem_req_o <= 1'b1;
			mem_we_o  <= bus.wr;
		end
	end

	// completion pulse back to the sequencer
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			bus.done <= 1'b0;
		end else begin
			bus.done <= mem_req_o && mem_ack_i;
		end
	end

	assign bus.busy = mem_req_o;
endmodule
`default_nettype wire

// file: hw/ict_timing_seq.sv
`timescale 1ns/100ps
`default_nettype none
`include "ict_params.svh"
////////////////////////////////////////////////////////////////////////////
// Function
// - plus entries add address-calc clocks, reads, writes
// - immediate counts include extension fetch and prefetch
// - immediate to data register: 16/4, long 28/6
// - immediate to memory: 20, 24, 40 plus; subtract immediate 12, 16, 24 plus
// - compare immediate: register 16/26, memory 16/24
// - quick to register 8/12, address 12
// - quick to memory: 12, 16, 24 plus; subtract quick 20, 24, 40 plus
// - clear/negate/complement: 8/10 register, memory 12/16/24
// - decimal negate 10/12; test 8 clocks
// - set-on-condition 8 false, 10 true, memory 12
// - test-and-set: 8 register, 14 memory
// - register shift: 10+2n, long 12+2n
// - memory shift: word, 16 clocks, 2/2
// - register bit ops: 12, 14, 10; static 20, 22, 18
// - memory bit ops: 12 or 20; test 8/16
// - conditional jump: taken 18, not-taken 12/20
// - subroutine call 34 (4/4); jump 18
// - loop: taken 18, true 20, false exit 26
// - bounds check: trap 68 (8/6), else 14
// - overflow trap: trap 66 (10/6), else 8
module ict_timing_seq #(
	parameter int CLK_W = `ICT_CLK_W, // clock-count width
	parameter int CYC_W = `ICT_CYC_W  // bus-cycle count width
) (
	input  wire logic             core_clk_i,
	input  wire logic             rst_i,
	input  wire logic             start_i,      // begin one instruction
	input  wire logic [4:0]       op_i,         // ict_pkg::ict_op_t code
	input  wire logic [1:0]       size_i,       // byte/word/long
	input  wire logic [1:0]       dst_i,        // ict_pkg::ict_dst_t code
	input  wire logic             cond_i,       // condition / trap / taken
	input  wire logic             loop_exit_i,  // loop counter expired
	input  wire logic             static_bit_i, // static bit number
	input  wire logic             word_disp_i,  // word displacement
	input  wire logic [5:0]       shift_n_i,    // shift count n
	input  wire logic [7:0]       ea_clks_i,    // address-calc clocks
	input  wire logic [3:0]       ea_rd_i,      // address-calc reads
	input  wire logic [3:0]       ea_wr_i,      // address-calc writes
	input  wire logic             mem_ack_i,    // memory finished a cycle
	output logic                  mem_req_o,    // bus cycle strobe
	output logic                  mem_we_o,     // bus cycle is a write
	output logic                  busy_o,       // instruction in progress
	output logic                  done_o,       // instruction finished pulse
	output logic [CLK_W-1:0]      total_clks_o, // clocks of last instruction
	output logic [CYC_W-1:0]      total_rd_o,   // reads of last instruction
	output logic [CYC_W-1:0]      total_wr_o    // writes of last instruction
);
	////////////////////////////////////////////////////////////////////////
	// base table lookup
	function automatic ict_pkg::ict_entry_t ent(input logic [7:0] c,
			input logic [4:0] r, input logic [4:0] w, input logic p);
		ict_pkg::ict_entry_t e;
		e.clks = c;
		e.rd   = r;
		e.wr   = w;
		e.plus = p;
		return e;
	endfunction

	// size-indexed memory triple used by many classes (12/16/24 style)
	function automatic ict_pkg::ict_entry_t mem_rmw(input logic [1:0] sz,
			input logic [7:0] cb, input logic [7:0] cw, input logic [7:0] cl,
			input logic [4:0] rd, input logic [4:0] rl);
		ict_pkg::ict_entry_t e;
		if (sz == `ICT_SZ_BYTE) begin
			e = ent(cb, rd, 5'h01, 1'b1);
		end else if (sz == `ICT_SZ_WORD) begin
			e = ent(cw, rd, 5'h02, 1'b1);
		end else begin
			e = ent(cl, rl, 5'h04, 1'b1);
		end
		return e;
	endfunction

	function automatic ict_pkg::ict_entry_t lookup(input ict_pkg::ict_op_t op,
			input logic [1:0] sz, input ict_pkg::ict_dst_t dst,
			input logic cnd, input logic lx, input logic st,
			input logic wd, input logic [5:0] n);
		ict_pkg::ict_entry_t e;
		logic is_long;
		logic is_mem;
		is_long = (sz == `ICT_SZ_LONG);
		is_mem  = (dst == ict_pkg::ICT_DST_MEM);
		e = ent(8'h08, 5'h02, 5'h00, 1'b0);
		case (op)
			ict_pkg::ICT_ADD_IMMEDIATE, ict_pkg::ICT_AND_IMMEDIATE,
			ict_pkg::ICT_XOR_IMMEDIATE, ict_pkg::ICT_OR_IMMEDIATE: begin
				if (is_mem) begin
					e = mem_rmw(sz, 8'h14, 8'h18, 8'h28, 5'h04, 5'h06);
				end else begin
					e = is_long ? ent(8'h1C, 5'h06, 5'h00, 1'b0)
						: ent(8'h10, 5'h04, 5'h00, 1'b0);
				end
			end
			ict_pkg::ICT_SUBTRACT_QUICK: begin
				if (is_mem) begin
					e = mem_rmw(sz, 8'h14, 8'h18, 8'h28, 5'h04, 5'h06);
				end else if (dst == ict_pkg::ICT_DST_ADDR || is_long) begin
					e = ent(8'h0C, 5'h02, 5'h00, 1'b0);
				end else begin
					e = ent(8'h08, 5'h02, 5'h00, 1'b0);
				end
			end
			ict_pkg::ICT_SUBTRACT_IMMEDIATE: begin
				if (is_mem) begin
					e = mem_rmw(sz, 8'h0C, 8'h10, 8'h18, 5'h02, 5'h02);
				end else begin
					e = is_long ? ent(8'h1C, 5'h06, 5'h00, 1'b0)
						: ent(8'h10, 5'h04, 5'h00, 1'b0);
				end
			end
			ict_pkg::ICT_ADD_QUICK: begin
				if (is_mem) begin
					e = mem_rmw(sz, 8'h0C, 8'h10, 8'h18, 5'h02, 5'h02);
				end else if (dst == ict_pkg::ICT_DST_ADDR || is_long) begin
					e = ent(8'h0C, 5'h02, 5'h00, 1'b0);
				end else begin
					e = ent(8'h08, 5'h02, 5'h00, 1'b0);
				end
			end
			ict_pkg::ICT_COMPARE_IMMEDIATE: begin
				// no write cycle: the compare only sets flags
				if (is_long) begin
					e = ent(is_mem ? 8'h18 : 8'h1A, 5'h06, 5'h00, 1'b0);
				end else begin
					e = ent(8'h10, 5'h04, 5'h00, 1'b0);
				end
			end
			ict_pkg::ICT_CLEAR_OPERAND, ict_pkg::ICT_TWOS_COMPLEMENT_OP,
			ict_pkg::ICT_EXTENDED_TWOS_COMPLEMENT_OP,
			ict_pkg::ICT_LOGICAL_COMPLEMENT: begin
				if (is_mem) begin
					e = mem_rmw(sz, 8'h0C, 8'h10, 8'h18, 5'h02, 5'h02);
				end else begin
					e = ent(is_long ? 8'h0A : 8'h08, 5'h02, 5'h00, 1'b0);
				end
			end
			ict_pkg::ICT_DECIMAL_NEGATE: begin
				e = is_mem ? ent(8'h0C, 5'h02, 5'h01, 1'b1)
					: ent(8'h0A, 5'h02, 5'h00, 1'b0);
			end
			ict_pkg::ICT_OPERAND_TEST: begin
				e = ent(8'h08, 5'h02, 5'h00, is_mem);
			end
			ict_pkg::ICT_SET_ON_CONDITION: begin
				if (is_mem) begin
					e = ent(8'h0C, 5'h02, 5'h01, 1'b1);
				end else begin
					e = ent(cnd ? 8'h0A : 8'h08, 5'h02, 5'h00, 1'b0);
				end
			end
			ict_pkg::ICT_TEST_AND_SET: begin
				e = is_mem ? ent(8'h0E, 5'h02, 5'h01, 1'b1)
					: ent(8'h08, 5'h02, 5'h00, 1'b0);
			end
			ict_pkg::ICT_SHIFT_ROTATE: begin
				if (is_mem) begin
					e = ent(8'h10, 5'h02, 5'h02, 1'b1);
				end else begin
					e = ent((is_long ? 8'h0C : 8'h0A) + {1'b0, n, 1'b0},
						5'h02, 5'h00, 1'b0);
				end
			end
			ict_pkg::ICT_BIT_TOGGLE, ict_pkg::ICT_BIT_SET: begin
				if (is_mem) begin
					e = st ? ent(8'h14, 5'h04, 5'h01, 1'b1)
						: ent(8'h0C, 5'h02, 5'h01, 1'b1);
				end else begin
					e = st ? ent(8'h14, 5'h04, 5'h00, 1'b0)
						: ent(8'h0C, 5'h02, 5'h00, 1'b0);
				end
			end
			ict_pkg::ICT_BIT_CLEAR: begin
				if (is_mem) begin
					e = st ? ent(8'h14, 5'h04, 5'h01, 1'b1)
						: ent(8'h0C, 5'h02, 5'h01, 1'b1);
				end else begin
					e = st ? ent(8'h16, 5'h04, 5'h00, 1'b0)
						: ent(8'h0E, 5'h02, 5'h00, 1'b0);
				end
			end
			ict_pkg::ICT_BIT_TEST: begin
				if (is_mem) begin
					e = st ? ent(8'h10, 5'h04, 5'h00, 1'b1)
						: ent(8'h08, 5'h02, 5'h00, 1'b1);
				end else begin
					e = st ? ent(8'h12, 5'h04, 5'h00, 1'b0)
						: ent(8'h0A, 5'h02, 5'h00, 1'b0);
				end
			end
			ict_pkg::ICT_COND_JUMP: begin
				if (cnd) begin
					e = ent(8'h12, 5'h04, 5'h00, 1'b0);
				end else begin
					e = wd ? ent(8'h14, 5'h04, 5'h00, 1'b0)
						: ent(8'h0C, 5'h02, 5'h00, 1'b0);
				end
			end
			ict_pkg::ICT_UNCONDITIONAL_RELATIVE_JUMP: begin
				e = ent(8'h12, 5'h04, 5'h00, 1'b0);
			end
			ict_pkg::ICT_RELATIVE_SUBROUTINE_CALL: begin
				e = ent(8'h22, 5'h04, 5'h04, 1'b0);
			end
			ict_pkg::ICT_DECREMENT_AND_LOOP: begin
				// cond true: fall through; false: loop unless counter expired
				if (cnd) begin
					e = ent(8'h14, 5'h04, 5'h00, 1'b0);
				end else if (lx) begin
					e = ent(8'h1A, 5'h06, 5'h00, 1'b0);
				end else begin
					e = ent(8'h12, 5'h04, 5'h00, 1'b0);
				end
			end
			ict_pkg::ICT_BOUNDS_CHECK: begin
				e = cnd ? ent(8'h44, 5'h08, 5'h06, 1'b1)
					: ent(8'h0E, 5'h02, 5'h00, 1'b1);
			end
			ict_pkg::ICT_OVERFLOW_TRAP: begin
				e = cnd ? ent(8'h42, 5'h0A, 5'h06, 1'b0)
					: ent(8'h08, 5'h02, 5'h00, 1'b0);
			end
			default: begin
				e = ent(8'h08, 5'h02, 5'h00, 1'b0);
			end
		endcase
		return e;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// sequencer state
	typedef enum logic [1:0] {
		ICT_IDLE,
		ICT_ISSUE,
		ICT_WAIT,
		ICT_PAD
	} ict_state_t;

	ict_state_t       state;     // current phase
	logic [CLK_W-1:0] clk_goal;  // total clocks for this instruction
	logic [CYC_W-1:0] rd_goal;   // total reads
	logic [CYC_W-1:0] wr_goal;   // total writes
	logic [CLK_W-1:0] clk_cnt;   // clocks elapsed
	logic [CYC_W-1:0] rd_cnt;    // reads completed
	logic [CYC_W-1:0] wr_cnt;    // writes completed
	ict_pkg::ict_entry_t base;   // combinational table result
	logic             more_rd;   // reads still owed
	logic             more_wr;   // writes still owed

	ict_bus_if bus_if ();

	ict_bus_engine u_eng (
		.core_clk_i (core_clk_i),
		.rst_i      (rst_i),
		.bus        (bus_if.eng),
		.mem_req_o  (mem_req_o),
		.mem_we_o   (mem_we_o),
		.mem_ack_i  (mem_ack_i)
	);

	assign base = lookup(ict_pkg::ict_op_t'(op_i), size_i,
		ict_pkg::ict_dst_t'(dst_i), cond_i, loop_exit_i, static_bit_i,
		word_disp_i, shift_n_i);
	assign more_rd = (rd_cnt < rd_goal);
	assign more_wr = (wr_cnt < wr_goal);
	// reads go first (fetch, operand), writes last (result store)
	assign bus_if.req = (state == ICT_ISSUE) && (more_rd || more_wr) && !bus_if.busy;
	assign bus_if.wr  = !more_rd;

	////////////////////////////////////////////////////////////////////////
	// latch goals at start; plus entries gain address-calc cost
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			clk_goal <= '0;
			rd_goal  <= '0;
			wr_goal  <= '0;
		end else if (state == ICT_IDLE && start_i) begin
			clk_goal <= CLK_W'(base.clks + (base.plus ? ea_clks_i : 8'h00));
			rd_goal  <= CYC_W'(base.rd + (base.plus ? {1'b0, ea_rd_i} : 5'h00));
			wr_goal  <= CYC_W'(base.wr + (base.plus ? {1'b0, ea_wr_i} : 5'h00));
		end
	end

	// phase machine: issue each counted cycle, wait for memory, pad clocks
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			state <= ICT_IDLE;
		end else begin
			case (state)
				ICT_IDLE: begin
					if (start_i) begin
						state <= ICT_ISSUE;
					end
				end
				ICT_ISSUE: begin
					state <= (more_rd || more_wr) ? ICT_WAIT : ICT_PAD;
				end
				ICT_WAIT: begin
					if (bus_if.done) begin
						state <= ICT_ISSUE;
					end
				end
				ICT_PAD: begin
					// a slow memory can stretch past the nominal count
					if (clk_cnt + CLK_W'(1) >= clk_goal) begin
						state <= ICT_IDLE;
					end
				end
				default: begin
					state <= ICT_IDLE;
				end
			endcase
		end
	end

	// bus cycle counters
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			rd_cnt <= '0;
			wr_cnt <= '0;
		end else if (state == ICT_IDLE) begin
			rd_cnt <= '0;
			wr_cnt <= '0;
		end else if (bus_if.done) begin
			if (more_rd) begin
				rd_cnt <= rd_cnt + CYC_W'(1);
			end else begin
				wr_cnt <= wr_cnt + CYC_W'(1);
			end
		end
	end

	// clock period counter
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			clk_cnt <= '0;
		end else if (state == ICT_IDLE) begin
			clk_cnt <= '0;
		end else begin
			clk_cnt <= clk_cnt + CLK_W'(1);
		end
	end

	// status outputs
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			busy_o       <= 1'b0;
			done_o       <= 1'b0;
			total_clks_o <= '0;
			total_rd_o   <= '0;
			total_wr_o   <= '0;
		end else begin
			busy_o <= (state != ICT_IDLE) || start_i;
			done_o <= (state == ICT_PAD) && (clk_cnt + CLK_W'(1) >= clk_goal);
			if (state == ICT_PAD && clk_cnt + CLK_W'(1) >= clk_goal) begin
				total_clks_o <= clk_goal;
				total_rd_o   <= rd_cnt;
				total_wr_o   <= wr_cnt;
			end
		end
	end
endmodule
`default_nettype wire

// file: verification/ict_mem_model.sv
`timescale 1ns/100ps
`default_nettype none
// memory side of the core: completes each bus cycle after a set number of waits
module ict_mem_model (
	input  wire logic       core_clk_i,
	input  wire logic       rst_i,
	input  wire logic       mem_req_i, // bus cycle strobe from the core
	input  wire logic [3:0] wait_i,    // wait cycles before completion
	output logic            mem_ack_o  // current cycle complete
);
	logic [3:0] cnt; // cycles the current request has waited

	// count waits while a request is pending; restart after each completion
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			cnt <= 4'h0;
		end else if (mem_req_i && !mem_ack_o) begin
			cnt <= cnt + 4'h1;
		end else begin
			cnt <= 4'h0;
		end
	end

	// answers only a held strobe, so a dropped request is never completed
	assign mem_ack_o = mem_req_i && (cnt == wait_i);
endmodule
`default_nettype wire

// file: verification/ict_timing_chk.sv
`timescale 1ns/100ps
`default_nettype none
// watches the sequencer ports for bus handshakes and timing totals
module ict_timing_chk #(
	parameter int CLK_W = 8, // clock-count width
	parameter int CYC_W = 5  // bus-cycle count width
) (
	input wire logic             core_clk_i,
	input wire logic             rst_i,
	input wire logic             start_i,
	input wire logic [4:0]       op_i,
	input wire logic [1:0]       size_i,
	input wire logic [1:0]       dst_i,
	input wire logic             cond_i,
	input wire logic [7:0]       ea_clks_i,
	input wire logic [3:0]       ea_rd_i,
	input wire logic [3:0]       ea_wr_i,
	input wire logic             mem_ack_i,
	input wire logic             mem_req_o,
	input wire logic             mem_we_o,
	input wire logic             busy_o,
	input wire logic             done_o,
	input wire logic [CLK_W-1:0] total_clks_o,
	input wire logic [CYC_W-1:0] total_rd_o,
	input wire logic [CYC_W-1:0] total_wr_o
);
	logic [4:0] op_q;  // class of the running instruction
	logic [1:0] sz_q;  // its size
	logic [1:0] dst_q; // its destination
	logic       cnd_q; // its trap/taken flag
	logic [7:0] eac_q; // its address-calc clocks
	logic [3:0] ear_q; // its address-calc reads
	logic [3:0] eaw_q; // its address-calc writes

	// hold what was accepted, since the inputs may move during the run
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			op_q <= 5'h00;
			sz_q <= 2'h0;
			dst_q <= 2'h0;
			cnd_q <= 1'b0;
			eac_q <= 8'h00;
			ear_q <= 4'h0;
			eaw_q <= 4'h0;
		end else if (start_i && !busy_o && !done_o) begin
			op_q <= op_i;
			sz_q <= size_i;
			dst_q <= dst_i;
			cnd_q <= cond_i;
			eac_q <= ea_clks_i;
			ear_q <= ea_rd_i;
			eaw_q <= ea_wr_i;
		end
	end

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (rst_i);

	sequence s_take;
		start_i && !busy_o && !done_o;
	endsequence
	sequence s_cycle_end;
		mem_req_o && mem_ack_i;
	endsequence

	req_hold_a: assert property (mem_req_o && !mem_ack_i |=> mem_req_o && $stable(mem_we_o))
		else $error("bus request dropped or changed before completion");
	req_drop_a: assert property (s_cycle_end |=> !mem_req_o)
		else $error("bus request still high after completion");
	take_busy_a: assert property (s_take |=> busy_o)
		else $error("accepted instruction not busy");
	done_bound_a: assert property (s_take |-> ##[2:1000] done_o)
		else $error("instruction never finished");
	done_pulse_a: assert property (done_o |=> !done_o)
		else $error("finish pulse longer than one cycle");
	req_idle_a: assert property (mem_req_o |-> busy_o && !done_o)
		else $error("bus cycle outside an instruction");
	quick_reg_a: assert property (done_o && op_q == ict_pkg::ICT_ADD_QUICK
		&& dst_q == 2'h0 && sz_q != 2'h2 |-> total_clks_o == 8'h08 && total_rd_o == 5'h02)
		else $error("quick register figures wrong");
	imm_mem_a: assert property (done_o && op_q <= ict_pkg::ICT_OR_IMMEDIATE
		&& dst_q == 2'h2 && sz_q == 2'h2 |-> total_clks_o == 8'h28 + eac_q
		&& total_rd_o == 5'h06 + ear_q && total_wr_o == 5'h04 + eaw_q)
		else $error("immediate memory long figures wrong");
	call_a: assert property (done_o && op_q == ict_pkg::ICT_RELATIVE_SUBROUTINE_CALL
		|-> total_clks_o == 8'h22 && total_wr_o == 5'h04)
		else $error("subroutine call figures wrong");
	trap_a: assert property (done_o && op_q == ict_pkg::ICT_OVERFLOW_TRAP
		|-> total_clks_o == (cnd_q ? 8'h42 : 8'h08) && total_rd_o == (cnd_q ? 5'h0A : 5'h02))
		else $error("overflow trap figures wrong");
endmodule

bind ict_timing_seq ict_timing_chk #(.CLK_W(CLK_W), .CYC_W(CYC_W)) u_ict_timing_chk (
	.core_clk_i(core_clk_i), .rst_i(rst_i), .start_i(start_i), .op_i(op_i), .size_i(size_i),
	.dst_i(dst_i), .cond_i(cond_i), .ea_clks_i(ea_clks_i), .ea_rd_i(ea_rd_i),
	.ea_wr_i(ea_wr_i), .mem_ack_i(mem_ack_i), .mem_req_o(mem_req_o), .mem_we_o(mem_we_o),
	.busy_o(busy_o), .done_o(done_o), .total_clks_o(total_clks_o),
	.total_rd_o(total_rd_o), .total_wr_o(total_wr_o));
`default_nettype wire

// file: verification/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	localparam logic [7:0] EA_C = 8'h0C; // address-calc cost, room for its bus cycles
	localparam logic [3:0] EA_R = 4'h2;
	localparam logic [3:0] EA_W = 4'h1;
	logic       core_clk = 1'b0;
	logic       rst      = 1'b1;
	logic       start    = 1'b0;
	logic [4:0] op       = 5'h00;
	logic [1:0] sz       = 2'h0;
	logic [1:0] dst      = 2'h0;
	logic [3:0] fl       = 4'h0;  // cond, loop exit, static bit, word disp
	logic [5:0] n        = 6'h00;
	logic [3:0] mem_wait = 4'h0;  // memory wait cycles
	logic       mem_req, mem_we, mem_ack, busy, done;
	logic [7:0] tot_c;
	logic [4:0] tot_r, tot_w;
	int         failures = 0;
	int         num_checks = 0;
	int         rd_seen = 0;      // completed reads on the bus
	int         wr_seen = 0;      // completed writes on the bus

	always #5 core_clk = ~core_clk;

	// tally handshakes independently of the totals the core reports
	always @(posedge core_clk) begin
		if (mem_req === 1'b1 && mem_ack === 1'b1) begin
			if (mem_we === 1'b1) wr_seen++;
			else rd_seen++;
		end
	end

	ict_timing_seq u_ict_timing_seq (.core_clk_i(core_clk), .rst_i(rst), .start_i(start),
		.op_i(op), .size_i(sz), .dst_i(dst), .cond_i(fl[3]), .loop_exit_i(fl[2]),
		.static_bit_i(fl[1]), .word_disp_i(fl[0]), .shift_n_i(n), .ea_clks_i(EA_C),
		.ea_rd_i(EA_R), .ea_wr_i(EA_W), .mem_ack_i(mem_ack), .mem_req_o(mem_req),
		.mem_we_o(mem_we), .busy_o(busy), .done_o(done), .total_clks_o(tot_c),
		.total_rd_o(tot_r), .total_wr_o(tot_w));
	ict_mem_model u_ict_mem_model (.core_clk_i(core_clk), .rst_i(rst), .mem_req_i(mem_req),
		.wait_i(mem_wait), .mem_ack_o(mem_ack));

	////////////////////////////////////////////////////////////////////////
	task automatic check_c(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic check_n(input logic [4:0] got, input logic [4:0] exp);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// one instruction: start, wait for the finish pulse, judge totals and bus traffic
	task automatic go(input logic [4:0] o, input logic [1:0] s, input logic [1:0] d,
		input logic [3:0] f, input logic [7:0] c, input logic [4:0] r, input logic [4:0] w,
		input logic p);
		logic [7:0] ec;
		logic [4:0] er;
		logic [4:0] ew;
		int         k;
		int         r0;
		int         w0;
		ec = p ? c + EA_C : c;
		er = p ? r + {1'b0, EA_R} : r;
		ew = p ? w + {1'b0, EA_W} : w;
		r0 = rd_seen;
		w0 = wr_seen;
		k = 0;
		@(posedge core_clk);
		op <= o;
		sz <= s;
		dst <= d;
		fl <= f;
		start <= 1'b1;
		@(posedge core_clk);
		start <= 1'b0;
		while (done !== 1'b1 && k < 2000) begin
			@(posedge core_clk);
			#1;
			k++;
		end
		if (k >= 2000) failures++;
		// slow memory stretches the run, so elapsed clocks are judged only when prompt
		if (mem_wait === 4'h0) check_c(8'(k), ec);
		check_c(tot_c, ec);
		check_n(tot_r, er);
		check_n(tot_w, ew);
		check_n(5'(rd_seen - r0), er);
		check_n(5'(wr_seen - w0), ew);
	endtask

	////////////////////////////////////////////////////////////////////////
	task automatic test_imm();
		for (int i = 0; i < 4; i++) begin
			go(ict_pkg::ICT_ADD_IMMEDIATE + 5'(i), 2'h0, 2'h0, 4'h0, 8'h10, 5'h04, 5'h00, 1'h0);
			go(ict_pkg::ICT_ADD_IMMEDIATE + 5'(i), 2'h2, 2'h0, 4'h0, 8'h1C, 5'h06, 5'h00, 1'h0);
			go(ict_pkg::ICT_ADD_IMMEDIATE + 5'(i), 2'h1, 2'h2, 4'h0, 8'h18, 5'h04, 5'h02, 1'h1);
		end
		go(ict_pkg::ICT_XOR_IMMEDIATE, 2'h2, 2'h2, 4'h0, 8'h28, 5'h06, 5'h04, 1'h1);
		go(ict_pkg::ICT_COMPARE_IMMEDIATE, 2'h2, 2'h0, 4'h0, 8'h1A, 5'h06, 5'h00, 1'h0);
		go(ict_pkg::ICT_COMPARE_IMMEDIATE, 2'h2, 2'h2, 4'h0, 8'h18, 5'h06, 5'h00, 1'h0);
		go(ict_pkg::ICT_ADD_QUICK, 2'h0, 2'h0, 4'h0, 8'h08, 5'h02, 5'h00, 1'h0);
		go(ict_pkg::ICT_ADD_QUICK, 2'h1, 2'h1, 4'h0, 8'h0C, 5'h02, 5'h00, 1'h0);
		go(ict_pkg::ICT_SUBTRACT_QUICK, 2'h2, 2'h0, 4'h0, 8'h0C, 5'h02, 5'h00, 1'h0);
		go(ict_pkg::ICT_ADD_QUICK, 2'h1, 2'h2, 4'h0, 8'h10, 5'h02, 5'h02, 1'h1);
		go(ict_pkg::ICT_SUBTRACT_QUICK, 2'h2, 2'h2, 4'h0, 8'h28, 5'h06, 5'h04, 1'h1);
		go(ict_pkg::ICT_SUBTRACT_IMMEDIATE, 2'h0, 2'h2, 4'h0, 8'h0C, 5'h02, 5'h01, 1'h1);
		$display("immediate and quick finished");
	endtask

	task automatic test_single();
		for (int i = 0; i < 4; i++) begin
			go(ict_pkg::ICT_CLEAR_OPERAND + 5'(i), 2'h2, 2'h0, 4'h0, 8'h0A, 5'h02, 5'h00, 1'h0);
			go(ict_pkg::ICT_CLEAR_OPERAND + 5'(i), 2'h0, 2'h2, 4'h0, 8'h0C, 5'h02, 5'h01, 1'h1);
		end
		go(ict_pkg::ICT_DECIMAL_NEGATE, 2'h0, 2'h0, 4'h0, 8'h0A, 5'h02, 5'h00, 1'h0);
		go(ict_pkg::ICT_DECIMAL_NEGATE, 2'h0, 2'h2, 4'h0, 8'h0C, 5'h02, 5'h01, 1'h1);
		go(ict_pkg::ICT_OPERAND_TEST, 2'h2, 2'h2, 4'h0, 8'h08, 5'h02, 5'h00, 1'h1);
		go(ict_pkg::ICT_SET_ON_CONDITION, 2'h0, 2'h0, 4'h0, 8'h08, 5'h02, 5'h00, 1'h0);
		go(ict_pkg::ICT_SET_ON_CONDITION, 2'h0, 2'h0, 4'h8, 8'h0A, 5'h02, 5'h00, 1'h0);
		go(ict_pkg::ICT_TEST_AND_SET, 2'h0, 2'h2, 4'h0, 8'h0E, 5'h02, 5'h01, 1'h1);
		n <= 6'h05;
		go(ict_pkg::ICT_SHIFT_ROTATE, 2'h1, 2'h0, 4'h0, 8'h14, 5'h02, 5'h00, 1'h0);
		n <= 6'h3F;
		go(ict_pkg::ICT_SHIFT_ROTATE, 2'h2, 2'h0, 4'h0, 8'h8A, 5'h02, 5'h00, 1'h0);
		go(ict_pkg::ICT_SHIFT_ROTATE, 2'h1, 2'h2, 4'h0, 8'h10, 5'h02, 5'h02, 1'h1);
		$display("single operand and shift finished");
	endtask

	task automatic test_bits();
		for (int i = 0; i < 3; i++) begin
			go(ict_pkg::ICT_BIT_TOGGLE + 5'(i), 2'h0, 2'h2, 4'h0, 8'h0C, 5'h02, 5'h01, 1'h1);
			go(ict_pkg::ICT_BIT_TOGGLE + 5'(i), 2'h0, 2'h2, 4'h2, 8'h14, 5'h04, 5'h01, 1'h1);
		end
		go(ict_pkg::ICT_BIT_CLEAR, 2'h2, 2'h0, 4'h0, 8'h0E, 5'h02, 5'h00, 1'h0);
		go(ict_pkg::ICT_BIT_TEST, 2'h2, 2'h0, 4'h0, 8'h0A, 5'h02, 5'h00, 1'h0);
		go(ict_pkg::ICT_BIT_CLEAR, 2'h2, 2'h0, 4'h2, 8'h16, 5'h04, 5'h00, 1'h0);
		go(ict_pkg::ICT_BIT_TEST, 2'h0, 2'h2, 4'h2, 8'h10, 5'h04, 5'h00, 1'h1);
		$display("bit operations finished");
	endtask

	task automatic test_branch();
		go(ict_pkg::ICT_COND_JUMP, 2'h0, 2'h0, 4'h8, 8'h12, 5'h04, 5'h00, 1'h0);
		go(ict_pkg::ICT_COND_JUMP, 2'h0, 2'h0, 4'h0, 8'h0C, 5'h02, 5'h00, 1'h0);
		go(ict_pkg::ICT_COND_JUMP, 2'h0, 2'h0, 4'h1, 8'h14, 5'h04, 5'h00, 1'h0);
		go(ict_pkg::ICT_UNCONDITIONAL_RELATIVE_JUMP, 2'h0, 2'h0, 4'h0, 8'h12, 5'h04, 5'h00,
			1'h0);
		go(ict_pkg::ICT_RELATIVE_SUBROUTINE_CALL, 2'h0, 2'h0, 4'h1, 8'h22, 5'h04, 5'h04, 1'h0);
		go(ict_pkg::ICT_DECREMENT_AND_LOOP, 2'h1, 2'h0, 4'h8, 8'h14, 5'h04, 5'h00, 1'h0);
		go(ict_pkg::ICT_DECREMENT_AND_LOOP, 2'h1, 2'h0, 4'h4, 8'h1A, 5'h06, 5'h00, 1'h0);
		go(ict_pkg::ICT_DECREMENT_AND_LOOP, 2'h1, 2'h0, 4'h0, 8'h12, 5'h04, 5'h00, 1'h0);
		go(ict_pkg::ICT_BOUNDS_CHECK, 2'h1, 2'h2, 4'h8, 8'h44, 5'h08, 5'h06, 1'h1);
		go(ict_pkg::ICT_BOUNDS_CHECK, 2'h1, 2'h2, 4'h0, 8'h0E, 5'h02, 5'h00, 1'h1);
		go(ict_pkg::ICT_OVERFLOW_TRAP, 2'h0, 2'h0, 4'h8, 8'h42, 5'h0A, 5'h06, 1'h0);
		go(ict_pkg::ICT_OVERFLOW_TRAP, 2'h0, 2'h0, 4'h0, 8'h08, 5'h02, 5'h00, 1'h0);
		$display("conditional finished");
	endtask

	// slow memory, and a second start while busy that must be ignored
	task automatic test_slow();
		int r0;
		mem_wait <= 4'h3;
		fork
			go(ict_pkg::ICT_TWOS_COMPLEMENT_OP, 2'h1, 2'h2, 4'h0, 8'h10, 5'h02, 5'h02, 1'h1);
			begin
				repeat (6) @(posedge core_clk);
				op <= ict_pkg::ICT_OVERFLOW_TRAP;
				start <= 1'b1;
				@(posedge core_clk);
				start <= 1'b0;
			end
		join
		r0 = rd_seen + wr_seen;
		repeat (40) @(posedge core_clk);
		check_n(5'(rd_seen + wr_seen - r0), 5'h00);
		mem_wait <= 4'h0;
		$display("slow memory finished");
	endtask

	task automatic close_out();
		$display("checks=%0d mismatches=%0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask

	initial begin
		repeat (6) @(posedge core_clk);
		rst <= 1'b0;
		test_imm();
		test_single();
		test_bits();
		test_branch();
		test_slow();
		close_out();
	end

	// watchdog well past the expected run of under two thousand cycles
	initial begin
		#500000;
		failures++;
		close_out();
	end
endmodule
`default_nettype wire
